// ---- design/dram_refresh_scheduling.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "dram_refresh_consts.svh"
// Behaviour
// - Refresh decoded from chip select and command bits.
// - Per-bank target advances zero to seven, wraps.
// - Refreshing bank refuses access; others stay usable.
// - Per-bank refresh leaves its bank idle.
// - All-bank refresh clears the per-bank target.
// - All-bank refresh leaves every bank idle.
// - Self refresh entry decoded with clock gate low.
// - Self refresh keeps data, ignores all but gate.
// - Internal all-bank refresh within minimum stay time.
// - Internal clock gated off in self refresh until the exit phase begins.

module dram_refresh_scheduling #(
	parameter int NBANK = `NBANK,
	parameter int CW = `CNT_W
) (
	// Clocks and reset
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic memClk,
	// Command/address pins
	input wire logic cke,
	input wire logic csN,
	input wire logic [`CA_W-1:0] ca,
	input wire logic [`BANK_W-1:0] bankAddr,
	// Status
	output logic [NBANK-1:0] bankBusy,
	output logic selfRefreshActive,
	output logic internalClockEnable,
	output logic internalRefresh,
	output dram_refresh_pkg::srState_t srState,
	output logic accessRejected,
	output logic [`BANK_W-1:0] refreshTarget
);
	import dram_refresh_pkg::*;

	localparam logic [CW-1:0] PB_LOAD = CW'(`PB_CYC);
	localparam logic [CW-1:0] AB_LOAD = CW'(`AB_CYC);
	localparam logic [CW-1:0] STAY_LOAD = CW'(`SR_MIN_STAY_CYC);
	localparam logic [CW-1:0] EXIT_LOAD = CW'(`SR_EXIT_CYC);
	localparam logic [CW-1:0] REFI_LOAD = CW'(`REFRESH_INTERVAL_CYC);
	localparam int STAY_I = `SR_MIN_STAY_CYC;
	localparam int PB_I = `PB_CYC + 1;

	logic [1:0] rst_ff;
	logic rstnCore;
	logic [`EV_N-1:0] evS1_ff, evS2_ff, evS3_ff, evPulse;
	logic [1:0] ckeS_ff;
	srState_t state_ff, nxt_state;
	logic [CW-1:0] abCnt_ff, nxt_abCnt, refTmr_ff, nxt_refTmr;
	logic [CW-1:0] stay_ff, nxt_stay, exit_ff, nxt_exit;
	logic intRef_ff, nxt_intRef;
	logic [NBANK-1:0] busy_ff, nxt_busy;
	logic srAct_ff, clkEn_ff;

	core_link_if lnk ();

	dram_cmd_decoder #(.NBANK(NBANK)) u_dec (
		.memClk(memClk),
		.rstn(rstn),
		.cke(cke),
		.csN(csN),
		.ca(ca),
		.bankAddr(bankAddr),
		.lnk(lnk.link),
		.accessRejected(accessRejected),
		.refreshTarget(refreshTarget)
	);

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rst_ff <= 2'b00;
		end else begin
			rst_ff <= {rst_ff[0], 1'b1};
		end
	end
	assign rstnCore = rst_ff[1];

	// Toggles from the link domain become one-cycle event pulses here.
	always_ff @(posedge sys_clk or negedge rstnCore) begin
		if (!rstnCore) begin
			evS1_ff <= '0;
			evS2_ff <= '0;
			evS3_ff <= '0;
			ckeS_ff <= 2'b00;
		end else begin
			evS1_ff <= lnk.evToggle;
			evS2_ff <= evS1_ff;
			evS3_ff <= evS2_ff;
			ckeS_ff <= {ckeS_ff[0], cke};
		end
	end
	assign evPulse = evS2_ff ^ evS3_ff;

	// Per-bank refresh timers; the bank is busy, then idle again.
	for (genvar g = 0; g < NBANK; g++) begin : g_bank
		logic [CW-1:0] cnt_ff, nxt_cnt;
		always_comb begin
			nxt_cnt = cnt_ff;
			if (evPulse[`EV_PB] && lnk.pbBank == `BANK_W'(g)) begin
				nxt_cnt = PB_LOAD;
			end else if (cnt_ff != '0) begin
				nxt_cnt = cnt_ff - 1'b1;
			end
		end
		always_ff @(posedge sys_clk or negedge rstnCore) begin
			if (!rstnCore) begin
				cnt_ff <= '0;
			end else begin
				cnt_ff <= nxt_cnt;
			end
		end
		assign nxt_busy[g] = (nxt_cnt != '0) || (nxt_abCnt != '0);
		chk_pb_idle_after: assert property (@(posedge sys_clk) disable iff (!rstnCore)
			(evPulse[`EV_PB] && lnk.pbBank == `BANK_W'(g) && abCnt_ff == '0)
			|=> bankBusy[g] ##[1:PB_I] !bankBusy[g])
			else $error("per-bank refresh did not return bank to idle");
	end

	// All-bank refresh and self refresh sequencing.
	always_comb begin
		nxt_state = state_ff;
		nxt_abCnt = (abCnt_ff != '0) ? abCnt_ff - 1'b1 : abCnt_ff;
		nxt_refTmr = refTmr_ff;
		nxt_stay = stay_ff;
		nxt_exit = exit_ff;
		nxt_intRef = 1'b0;
		case (state_ff)
			SR_IDLE: begin
				if (evPulse[`EV_AB]) begin
					nxt_abCnt = AB_LOAD;
				end
				if (evPulse[`EV_SRE]) begin
					nxt_state = SR_IN;
					nxt_refTmr = '0;
					nxt_stay = STAY_LOAD;
				end
			end
			SR_IN: begin
				if (stay_ff != '0) begin
					nxt_stay = stay_ff - 1'b1;
				end
				// The internal timer keeps the array refreshed without a clock.
				if (refTmr_ff != '0) begin
					nxt_refTmr = refTmr_ff - 1'b1;
				end else if (abCnt_ff == '0) begin
					nxt_abCnt = AB_LOAD;
					nxt_refTmr = REFI_LOAD;
					nxt_intRef = 1'b1;
				end
				if (stay_ff == '0 && ckeS_ff[1]) begin
					nxt_state = SR_EXIT;
					nxt_exit = EXIT_LOAD;
				end
			end
			SR_EXIT: begin
				if (exit_ff != '0) begin
					nxt_exit = exit_ff - 1'b1;
				end else begin
					nxt_state = SR_IDLE;
				end
			end
			default: begin
				nxt_state = SR_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rstnCore) begin
		if (!rstnCore) begin
			state_ff <= SR_IDLE;
			abCnt_ff <= '0;
			refTmr_ff <= '0;
			stay_ff <= '0;
			exit_ff <= '0;
			intRef_ff <= 1'b0;
			busy_ff <= '0;
			srAct_ff <= 1'b0;
			clkEn_ff <= 1'b1;
		end else begin
			state_ff <= nxt_state;
			abCnt_ff <= nxt_abCnt;
			refTmr_ff <= nxt_refTmr;
			stay_ff <= nxt_stay;
			exit_ff <= nxt_exit;
			intRef_ff <= nxt_intRef;
			busy_ff <= nxt_busy;
			srAct_ff <= (nxt_state != SR_IDLE);
			clkEn_ff <= (nxt_state != SR_IN);
		end
	end

	assign lnk.bankBusy = busy_ff;
	assign lnk.srActive = srAct_ff;
	assign bankBusy = busy_ff;
	assign selfRefreshActive = srAct_ff;
	assign internalClockEnable = clkEn_ff;
	assign internalRefresh = intRef_ff;
	assign srState = state_ff;

	chk_sr_clock_gate: assert property (@(posedge sys_clk) disable iff (!rstnCore)
		state_ff == SR_IN |-> !internalClockEnable)
		else $error("internal clock running in self refresh");
	chk_sr_first_refresh: assert property (@(posedge sys_clk) disable iff (!rstnCore)
		($rose(state_ff == SR_IN) && abCnt_ff == '0) |-> ##[1:STAY_I] internalRefresh)
		else $error("no internal refresh within minimum stay");
	chk_ab_all_busy: assert property (@(posedge sys_clk) disable iff (!rstnCore)
		(evPulse[`EV_AB] && state_ff == SR_IDLE) |=> (&bankBusy) [*2] ##1 (bankBusy == '0))
		else $error("all-bank refresh did not hold then release every bank");
	chk_sr_refresh_busy: assert property (@(posedge sys_clk) disable iff (!rstnCore)
		internalRefresh |-> &bankBusy)
		else $error("internal refresh did not occupy all banks");
endmodule

`default_nettype wire

// ---- design/dram_refresh_consts.svh ----
`ifndef DRAM_REFRESH_CONSTS_SVH
`define DRAM_REFRESH_CONSTS_SVH

// Geometry.
`define NBANK 8
`define BANK_W 3
`define CA_W 4
`define CNT_W 8

// Command/address decode: compare (ca & mask) against value.
`define CA_REF_MASK 4'h7
`define CA_REF_VAL 4'h4
`define CA_ACT_MASK 4'h3
`define CA_ACT_VAL 4'h2
`define CA_RW_MASK 4'h3
`define CA_RW_VAL 4'h1
`define CA_PRE_MASK 4'hF
`define CA_PRE_VAL 4'hB
`define CA_AB_BIT 3

// Event slots carried by toggles from the link domain.
`define EV_N 3
`define EV_PB 0
`define EV_AB 1
`define EV_SRE 2

// Core clock rate and timing figures in nanoseconds.
`define SYS_CLK_MHZ 10
`define PB_CYCLE_NS 90
`define AB_CYCLE_NS 130
`define SR_MIN_STAY_NS 15
`define SR_EXIT_NS 140
`define REFRESH_INTERVAL_NS 7800

// Least times round up to whole core cycles.
`define NS_TO_CYC_UP(ns) (((ns) * `SYS_CLK_MHZ + 999) / 1000)
`define PB_CYC `NS_TO_CYC_UP(`PB_CYCLE_NS)
`define AB_CYC `NS_TO_CYC_UP(`AB_CYCLE_NS)
`define SR_MIN_STAY_CYC `NS_TO_CYC_UP(`SR_MIN_STAY_NS)
`define SR_EXIT_CYC `NS_TO_CYC_UP(`SR_EXIT_NS)
`define REFRESH_INTERVAL_CYC ((`REFRESH_INTERVAL_NS * `SYS_CLK_MHZ) / 1000)

`endif

// ---- design/dram_refresh_pkg.sv ----
package dram_refresh_pkg;

	typedef enum logic [1:0] {
		SR_IDLE = 2'b00,
		SR_IN = 2'b01,
		SR_EXIT = 2'b10
	} srState_t;

endpackage

// ---- design/core_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "dram_refresh_consts.svh"

interface core_link_if;
	logic [`EV_N-1:0] evToggle;
	logic [`BANK_W-1:0] pbBank;
	logic [`NBANK-1:0] bankBusy;
	logic srActive;

	modport link (
		output evToggle,
		output pbBank,
		input bankBusy,
		input srActive
	);

	modport core (
		input evToggle,
		input pbBank,
		output bankBusy,
		output srActive
	);
endinterface

`default_nettype wire

// ---- design/dram_cmd_decoder.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "dram_refresh_consts.svh"

module dram_cmd_decoder #(
	parameter int NBANK = `NBANK
) (
	// Link clock and reset
	input wire logic memClk,
	input wire logic rstn,
	// Command/address pins
	input wire logic cke,
	input wire logic csN,
	input wire logic [`CA_W-1:0] ca,
	input wire logic [`BANK_W-1:0] bankAddr,
	// Core side
	core_link_if.link lnk,
	// Status
	output logic accessRejected,
	output logic [`BANK_W-1:0] refreshTarget
);
	logic [1:0] lrst_ff;
	logic lrstn;
	logic [NBANK-1:0] busyS1_ff, busyS2_ff;
	logic srS1_ff, srS2_ff;
	logic srLatched_ff, nxt_srLatched;
	logic [`BANK_W-1:0] refBank_ff, nxt_refBank;
	logic [`BANK_W-1:0] pbBank_ff, nxt_pbBank;
	logic [`EV_N-1:0] evTog_ff, nxt_evTog;
	logic reject_ff, nxt_reject;
	logic ignore, sel, isRef, pbCmd, abCmd, sreCmd, actCmd, rwCmd;

	always_ff @(posedge memClk or negedge rstn) begin
		if (!rstn) begin
			lrst_ff <= 2'b00;
		end else begin
			lrst_ff <= {lrst_ff[0], 1'b1};
		end
	end
	assign lrstn = lrst_ff[1];

	always_ff @(posedge memClk or negedge lrstn) begin
		if (!lrstn) begin
			busyS1_ff <= '0;
			busyS2_ff <= '0;
			srS1_ff <= 1'b0;
			srS2_ff <= 1'b0;
		end else begin
			busyS1_ff <= lnk.bankBusy;
			busyS2_ff <= busyS1_ff;
			srS1_ff <= lnk.srActive;
			srS2_ff <= srS1_ff;
		end
	end

	// Inputs other than the clock gate are ignored in self refresh.
	assign ignore = srLatched_ff || srS2_ff;
	assign sel = !csN && !ignore;
	assign isRef = sel && ((ca & `CA_REF_MASK) == `CA_REF_VAL);
	assign pbCmd = isRef && cke && !ca[`CA_AB_BIT];
	assign abCmd = isRef && cke && ca[`CA_AB_BIT];
	assign sreCmd = isRef && !cke;
	assign actCmd = sel && cke && ((ca & `CA_ACT_MASK) == `CA_ACT_VAL);
	assign rwCmd = sel && cke && ((ca & `CA_RW_MASK) == `CA_RW_VAL);

	always_comb begin
		nxt_srLatched = srLatched_ff;
		if (sreCmd) begin
			nxt_srLatched = 1'b1;
		end else if (srS2_ff) begin
			nxt_srLatched = 1'b0;
		end
		nxt_refBank = refBank_ff;
		nxt_pbBank = pbBank_ff;
		if (pbCmd) begin
			nxt_refBank = refBank_ff + 1'b1;
			nxt_pbBank = refBank_ff;
		end else if (abCmd || sreCmd) begin
			nxt_refBank = '0;
		end
		nxt_evTog = evTog_ff ^ {sreCmd, abCmd, pbCmd};
		// The bank under refresh refuses access; other banks stay usable.
		nxt_reject = (actCmd || rwCmd) && busyS2_ff[bankAddr];
	end

	always_ff @(posedge memClk or negedge lrstn) begin
		if (!lrstn) begin
			srLatched_ff <= 1'b0;
			refBank_ff <= '0;
			pbBank_ff <= '0;
			evTog_ff <= '0;
			reject_ff <= 1'b0;
		end else begin
			srLatched_ff <= nxt_srLatched;
			refBank_ff <= nxt_refBank;
			pbBank_ff <= nxt_pbBank;
			evTog_ff <= nxt_evTog;
			reject_ff <= nxt_reject;
		end
	end

	assign lnk.evToggle = evTog_ff;
	assign lnk.pbBank = pbBank_ff;
	assign accessRejected = reject_ff;
	assign refreshTarget = refBank_ff;

	chk_pb_counter_step: assert property (@(posedge memClk) disable iff (!lrstn)
		pbCmd |=> refBank_ff == $past(refBank_ff) + 1'b1 && $changed(evTog_ff[`EV_PB]))
		else $error("per-bank target did not advance");
	chk_ab_counter_zero: assert property (@(posedge memClk) disable iff (!lrstn)
		abCmd |=> refBank_ff == '0 && $changed(evTog_ff[`EV_AB]))
		else $error("all-bank refresh did not clear target");
	chk_ref_decode: assert property (@(posedge memClk) disable iff (!lrstn)
		(!csN && !ignore && cke && ca[2:0] == 3'h4) |=> evTog_ff != $past(evTog_ff))
		else $error("refresh command not decoded");
	chk_sre_decode: assert property (@(posedge memClk) disable iff (!lrstn)
		(!csN && !ignore && !cke && ca[2:0] == 3'h4) |=> srLatched_ff ##1 ignore)
		else $error("self refresh entry not decoded");
	chk_sr_ignore: assert property (@(posedge memClk) disable iff (!lrstn)
		ignore |=> !accessRejected && $stable(evTog_ff) && $stable(refBank_ff))
		else $error("input acted on in self refresh");
	chk_reject_busy: assert property (@(posedge memClk) disable iff (!lrstn)
		(actCmd || rwCmd) |=> accessRejected == $past(busyS2_ff[bankAddr]))
		else $error("access refusal wrong for bank state");
endmodule

`default_nettype wire

// ---- verification/mem_ctrl_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module mem_ctrl_model (
	// Link clock and command pins
	output var logic memClk,
	output var logic cke,
	output var logic csN,
	output var logic [3:0] ca,
	output var logic [2:0] bankAddr
);
	logic clkRun;
	logic [2:0] pbPtr;

	initial begin
		memClk = 1'b0;
		cke = 1'b1;
		csN = 1'b1;
		ca = 4'h0;
		bankAddr = 3'h0;
		clkRun = 1'b1;
		pbPtr = 3'h0;
		#17;
		forever begin
			#62.5;
			if (clkRun) begin
				memClk = ~memClk;
			end
		end
	end

	// The gap after each command holds all spacing owed after it.
	task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic k, input int len,
		input int gap);
		@(negedge memClk);
		csN = 1'b0;
		ca = c;
		bankAddr = b;
		cke = k;
		if (c[2:0] == 3'h4 && k) pbPtr = c[3] ? 3'h0 : pbPtr + 3'h1;
		repeat (len) @(negedge memClk);
		csN = 1'b1;
		ca = ~c;
		bankAddr = ~b;
		repeat (gap) @(negedge memClk);
	endtask

	// The clock stops only after a falling edge, so it rests low.
	task automatic halt();
		@(negedge memClk);
		clkRun = 1'b0;
	endtask

	// Clock is restarted and stable before the gate rises, then no-ops follow.
	task automatic wake();
		clkRun = 1'b1;
		pbPtr = 3'h0;
		repeat (3) @(negedge memClk);
		cke = 1'b1;
		repeat (10) @(negedge memClk);
	endtask
endmodule

`default_nettype wire

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "dram_refresh_consts.svh"

module tb_top;
	import dram_refresh_pkg::*;
	logic sys_clk, rstn, memClk, cke, csN, sawExit;
	logic [`CA_W-1:0] ca;
	logic [`BANK_W-1:0] bankAddr, refreshTarget;
	logic [`NBANK-1:0] bankBusy, seenBusy;
	logic selfRefreshActive, internalClockEnable, internalRefresh, accessRejected;
	srState_t srState;
	int errTotal, testsRun, rejCount, irqCount;

	mem_ctrl_model i_mem_ctrl_model (.memClk(memClk), .cke(cke), .csN(csN), .ca(ca),
		.bankAddr(bankAddr));
	dram_refresh_scheduling i_dram_refresh_scheduling (.sys_clk(sys_clk), .rstn(rstn),
		.memClk(memClk), .cke(cke), .csN(csN), .ca(ca), .bankAddr(bankAddr),
		.bankBusy(bankBusy), .selfRefreshActive(selfRefreshActive),
		.internalClockEnable(internalClockEnable), .internalRefresh(internalRefresh),
		.srState(srState), .accessRejected(accessRejected), .refreshTarget(refreshTarget));

	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) begin
		seenBusy <= seenBusy | bankBusy;
		if (internalRefresh === 1'b1) irqCount <= irqCount + 1;
		if (srState === SR_EXIT) sawExit <= 1'b1;
	end

	always @(posedge memClk) begin
		if (accessRejected === 1'b1) rejCount <= rejCount + 1;
	end

	task automatic chk(input bit ok, input string msg);
		testsRun++;
		if (!ok) begin
			errTotal++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask

	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", testsRun, errTotal);
		if (errTotal == 0 && testsRun > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	task automatic t_perbank();
		for (int i = 0; i < 9; i++) begin
			@(negedge sys_clk);
			seenBusy = '0;
			i_mem_ctrl_model.issue(4'h4, 3'h0, 1'b1, 1, 6);
			chk(refreshTarget === 3'((i + 1) % `NBANK), "per-bank target order");
			chk(refreshTarget === i_mem_ctrl_model.pbPtr, "controller pointer out of step");
			chk(seenBusy === (8'h01 << (i % `NBANK)), "wrong bank refreshed");
			chk(bankBusy === 8'h00, "bank not idle after refresh");
		end
		$display("Test per-bank order done");
	endtask

	task automatic t_access();
		rejCount = 0;
		i_mem_ctrl_model.issue(4'h4, 3'h0, 1'b1, 1, 0);
		i_mem_ctrl_model.issue(4'h1, 3'h2, 1'b1, 8, 0);
		chk(rejCount == 0, "other bank refused");
		@(negedge sys_clk);
		seenBusy = '0;
		i_mem_ctrl_model.issue(4'hC, 3'h0, 1'b1, 1, 0);
		i_mem_ctrl_model.issue(4'h1, 3'h3, 1'b1, 12, 2);
		chk(rejCount > 0, "busy bank accepted access");
		chk(refreshTarget === 3'h0, "target not cleared");
		chk(seenBusy === 8'hFF, "not all banks refreshed");
		chk(bankBusy === 8'h00, "banks not idle");
		$display("Test access and all-bank done");
	endtask

	task automatic t_selfref();
		i_mem_ctrl_model.issue(4'h4, 3'h0, 1'b1, 1, 6);
		chk(refreshTarget === 3'h1, "target before entry");
		@(negedge sys_clk);
		irqCount = 0;
		seenBusy = '0;
		i_mem_ctrl_model.issue(4'h4, 3'h0, 1'b0, 1, 2);
		repeat (6) @(negedge sys_clk);
		chk(srState === SR_IN && selfRefreshActive === 1'b1, "no entry");
		chk(internalClockEnable === 1'b0, "clock not gated");
		chk(irqCount >= 1 && seenBusy === 8'hFF, "no refresh at entry");
		i_mem_ctrl_model.halt();
		repeat (200) @(negedge sys_clk);
		chk(irqCount >= 3, "timer refresh missing");
		chk(srState === SR_IN, "left self refresh");
		i_mem_ctrl_model.wake();
		repeat (4) @(negedge sys_clk);
		chk(sawExit === 1'b1, "no exit phase");
		chk(srState === SR_IDLE && selfRefreshActive === 1'b0, "not idle");
		chk(internalClockEnable === 1'b1, "clock still gated");
		seenBusy = '0;
		i_mem_ctrl_model.issue(4'h4, 3'h0, 1'b1, 1, 6);
		chk(refreshTarget === 3'h1 && seenBusy === 8'h01, "counter not resynced");
		chk(refreshTarget === i_mem_ctrl_model.pbPtr, "pointer not resynced at exit");
		$display("Test self refresh done");
	endtask

	initial begin
		rstn = 1'b0;
		errTotal = 0;
		testsRun = 0;
		rejCount = 0;
		irqCount = 0;
		sawExit = 1'b0;
		seenBusy = '0;
		repeat (16) @(negedge sys_clk);
		rstn = 1'b1;
		repeat (8) @(negedge sys_clk);
		t_perbank();
		t_access();
		t_selfref();
		report_and_stop();
	end

	initial begin
		#500000;
		errTotal++;
		$display("[FAIL] %0t watchdog expired", $time);
		report_and_stop();
	end
endmodule

`default_nettype wire
